// *** pkg/hpd_pkg.sv ***
`default_nettype none
package hpd_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_OFF_SP  = 8'h0A;
    localparam logic [7:0] OFS_PORT_OFF_BP  = 8'h0B;
    localparam logic [7:0] OFS_DRAW_SP      = 8'h0C;
    localparam logic [7:0] OFS_DRAW_BP      = 8'h0D;
    localparam logic [7:0] OFS_CTRL_DRAW_SP = 8'h0E;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int         RENUMBER_BIT     = 3;
    localparam logic [7:0] RST_PORT_OFF     = 8'h00;
    localparam logic [7:0] RST_DRAW         = 8'h00;
    localparam logic [7:0] RST_CTRL_DRAW_SP = 8'h32;
    localparam logic [7:0] MASK_RSVD0       = 8'hFE;
    localparam int         SYNC_STAGES      = 3;
endpackage : hpd_pkg
`default_nettype wire

// *** rtl/hpd_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module hpd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s1     <= '0;
            s2     <= '0;
            s3     <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    sync_o[i] <= s3[i];
                end
            end
        end
    end
endmodule // hpd_sync
`default_nettype wire

// *** rtl/hpd_port_cfg.sv ***
`timescale 1ns/100ps
`default_nettype none
module hpd_port_cfg #(
    parameter int NPORT = 7
) (
    // Clock, reset, enable
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // Configuration byte port
    input  wire logic             cfg_wr_i,
    input  wire logic [7:0]       cfg_addr_i,
    input  wire logic [7:0]       cfg_wdata_i,
    output logic      [7:0]       cfg_rdata_o,
    // Mode and strap pins
    input  wire logic             use_defaults_i,
    input  wire logic             self_powered_i,
    input  wire logic             port_renumber_enable_i,
    input  wire logic [NPORT:1]   port_off_strap_positive_i,
    input  wire logic [NPORT:1]   port_off_strap_negative_i,
    // Results to the hub core
    output logic      [NPORT:1]   port_off_o,
    output logic      [3:0]       enabled_count_o,
    output logic      [3*NPORT-1:0] phys_of_logical_o,
    output logic      [7:0]       supply_draw_o,
    output logic      [7:0]       controller_draw_o
);
    logic [7:0]       self_powered_port_off_mask;
    logic [7:0]       bus_powered_port_off_mask;
    logic [7:0]       self_powered_supply_draw;
    logic [7:0]       bus_powered_supply_draw;
    logic [7:0]       controller_draw_self_powered;
    logic [NPORT:1]   strap_p;
    logic [NPORT:1]   strap_m;
    logic             mode_sp;
    logic             renum;
    logic             use_def_s;
    logic [4:0]       wr_sel;
    logic [NPORT:1]   next_off;
    logic [3:0]       next_count;
    logic [3*NPORT-1:0] next_map;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    hpd_sync #(.W(NPORT)) u_sync_p (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .async_i   (port_off_strap_positive_i),
        .sync_o    (strap_p)
    );
    hpd_sync #(.W(NPORT)) u_sync_m (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .async_i   (port_off_strap_negative_i),
        .sync_o    (strap_m)
    );
    // The defaults select is a board level too, so it is filtered like the straps
    hpd_sync #(.W(3)) u_sync_mode (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .async_i   ({use_defaults_i, self_powered_i, port_renumber_enable_i}),
        .sync_o    ({use_def_s, mode_sp, renum})
    );

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    always_comb begin
        wr_sel = 5'h00;
        // Writes to other offsets fall through and are ignored
        if (!(ce_i && cfg_wr_i)) begin
            wr_sel = 5'h00;
        end else if (cfg_addr_i == hpd_pkg::OFS_PORT_OFF_SP) begin
            wr_sel = 5'h01;
        end else if (cfg_addr_i == hpd_pkg::OFS_PORT_OFF_BP) begin
            wr_sel = 5'h02;
        end else if (cfg_addr_i == hpd_pkg::OFS_DRAW_SP) begin
            wr_sel = 5'h04;
        end else if (cfg_addr_i == hpd_pkg::OFS_DRAW_BP) begin
            wr_sel = 5'h08;
        end else if (cfg_addr_i == hpd_pkg::OFS_CTRL_DRAW_SP) begin
            wr_sel = 5'h10;
        end
    end

    // ------------------------------------------------------------
    // Configuration bytes, one flop group each
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            self_powered_port_off_mask <= hpd_pkg::RST_PORT_OFF;
        end else if (wr_sel[0]) begin
            // Bit 0 is dropped on write since port zero does not exist
            self_powered_port_off_mask <= cfg_wdata_i & hpd_pkg::MASK_RSVD0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_powered_port_off_mask <= hpd_pkg::RST_PORT_OFF;
        end else if (wr_sel[1]) begin
            bus_powered_port_off_mask <= cfg_wdata_i & hpd_pkg::MASK_RSVD0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            self_powered_supply_draw <= hpd_pkg::RST_DRAW;
        end else if (wr_sel[2]) begin
            self_powered_supply_draw <= cfg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_powered_supply_draw <= hpd_pkg::RST_DRAW;
        end else if (wr_sel[3]) begin
            bus_powered_supply_draw <= cfg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            controller_draw_self_powered <= hpd_pkg::RST_CTRL_DRAW_SP;
        end else if (wr_sel[4]) begin
            controller_draw_self_powered <= cfg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Read back, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            if (cfg_addr_i == hpd_pkg::OFS_PORT_OFF_SP) begin
                cfg_rdata_o <= self_powered_port_off_mask;
            end else if (cfg_addr_i == hpd_pkg::OFS_PORT_OFF_BP) begin
                cfg_rdata_o <= bus_powered_port_off_mask;
            end else if (cfg_addr_i == hpd_pkg::OFS_DRAW_SP) begin
                cfg_rdata_o <= self_powered_supply_draw;
            end else if (cfg_addr_i == hpd_pkg::OFS_DRAW_BP) begin
                cfg_rdata_o <= bus_powered_supply_draw;
            end else if (cfg_addr_i == hpd_pkg::OFS_CTRL_DRAW_SP) begin
                cfg_rdata_o <= controller_draw_self_powered;
            end else begin
                cfg_rdata_o <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Active off set, count and renumbering
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] k;
        k        = 4'h0;
        next_map = '0;
        // Straps: a port is off when either strap pin of it is high
        if (use_def_s) begin
            next_off = strap_p | strap_m;
        end else if (mode_sp) begin
            next_off = self_powered_port_off_mask[NPORT:1];
        end else begin
            next_off = bus_powered_port_off_mask[NPORT:1];
        end
        // Remap mode owns numbering elsewhere, so disables are not applied here
        if (renum) begin
            next_off = '0;
        end
        for (int p = 1; p <= NPORT; p++) begin
            if (!next_off[p]) begin
                next_map[3*k +: 3] = 3'(p);
                k = k + 4'h1;
            end
        end
        next_count = k;
    end

    // ------------------------------------------------------------
    // Outputs to the hub core
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            port_off_o <= '0;
        end else if (ce_i) begin
            port_off_o <= next_off;
        end
    end

    // Count and map move on the same edge as the off set, so they agree from the first enabled edge after reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            enabled_count_o <= 4'h0;
        end else if (ce_i) begin
            enabled_count_o <= next_count;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phys_of_logical_o <= '0;
        end else if (ce_i) begin
            phys_of_logical_o <= next_map;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            supply_draw_o <= hpd_pkg::RST_DRAW;
        end else if (ce_i) begin
            supply_draw_o <= mode_sp ? self_powered_supply_draw : bus_powered_supply_draw;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            controller_draw_o <= hpd_pkg::RST_CTRL_DRAW_SP;
        end else if (ce_i) begin
            controller_draw_o <= controller_draw_self_powered;
        end
    end
endmodule // hpd_port_cfg
`default_nettype wire

// *** tb/hpd_port_cfg_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module hpd_port_cfg_asserts #(
    parameter int NPORT = 7
) (
    // Clock, reset, enable
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // Configuration byte port
    input  wire logic             cfg_wr_i,
    input  wire logic [7:0]       cfg_addr_i,
    input  wire logic [7:0]       cfg_wdata_i,
    input  wire logic [7:0]       cfg_rdata_o,
    // Mode and strap pins
    input  wire logic             use_defaults_i,
    input  wire logic             self_powered_i,
    input  wire logic             port_renumber_enable_i,
    input  wire logic [NPORT:1]   port_off_strap_positive_i,
    input  wire logic [NPORT:1]   port_off_strap_negative_i,
    // Results watched
    input  wire logic [NPORT:1]   port_off_o,
    input  wire logic [3:0]       enabled_count_o,
    input  wire logic [7:0]       supply_draw_o,
    input  wire logic [7:0]       controller_draw_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Mode held 8 edges first, so it has crossed the input synchronisers
    property p_eff(m, ofs, obs, msk);
        (ce_i && self_powered_i == m && !use_defaults_i && !port_renumber_enable_i)[*8]
            ##0 cfg_wr_i && cfg_addr_i == ofs ##1 ce_i && !use_defaults_i |=> obs == ($past(cfg_wdata_i, 2) & msk);
    endproperty
    a_sp_port_mask: assert property (p_eff(1'b1, 8'h0A, {port_off_o, 1'b0}, 8'hFE)) else $error("sp mask");
    a_bp_port_mask: assert property (p_eff(1'b0, 8'h0B, {port_off_o, 1'b0}, 8'hFE)) else $error("bp mask");
    a_sp_draw_seen: assert property (p_eff(1'b1, 8'h0C, supply_draw_o, 8'hFF)) else $error("sp draw");
    a_bp_draw_seen: assert property (p_eff(1'b0, 8'h0D, supply_draw_o, 8'hFF)) else $error("bp draw");
    a_rsvd_bit_zero: assert property (ce_i && cfg_addr_i inside {8'h0A, 8'h0B} |=> !cfg_rdata_o[0]) else $error("bit0");
    // The first reset edge may race the flops, so one held edge is required first
    a_ctrl_draw_reset: assert property (disable iff (1'b0)
        rst_i && $past(rst_i) |-> controller_draw_o == 8'h32) else $error("ctrl");
    a_count_match: assert property (!$past(rst_i) |-> enabled_count_o == 4'(NPORT - $countones(port_off_o)))
        else $error("count");
    a_remap_no_off: assert property ((ce_i && port_renumber_enable_i)[*8] |-> port_off_o == '0) else $error("remap");
    a_strap_off_set: assert property ((ce_i && use_defaults_i && !port_renumber_enable_i
        && $stable(port_off_strap_positive_i) && $stable(port_off_strap_negative_i))[*8]
        |-> port_off_o == (port_off_strap_positive_i | port_off_strap_negative_i)) else $error("strap");
    c_remap: cover property (port_renumber_enable_i && port_off_o == '0);
    c_all_off: cover property (port_off_o == '1);
    c_strap: cover property (use_defaults_i && port_off_o != '0);
endmodule // hpd_port_cfg_asserts
bind hpd_port_cfg hpd_port_cfg_asserts #(.NPORT(NPORT)) u_asserts (.*);
`default_nettype wire

// *** tb/hpd_cfg_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module hpd_cfg_host (
    // Clock
    input  wire logic       clk_sys_i,
    // Read data from the block
    input  wire logic [7:0] cfg_rdata_i,
    // Write and address lines to the block
    output var  logic       cfg_wr_o,
    output var  logic [7:0] cfg_addr_o,
    output var  logic [7:0] cfg_wdata_o
);
    // ----------------------------------------
    // Configuration loader
    // ----------------------------------------
    initial {cfg_wr_o, cfg_addr_o, cfg_wdata_o} = 17'h0;
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys_i);
        #1;
        if (a inside {8'h0C, 8'h0E} && d > 8'h32) d = 8'h32;
        {cfg_wr_o, cfg_addr_o, cfg_wdata_o} = {1'b1, a, d};
        @(posedge clk_sys_i);
        #1;
        cfg_wr_o = 1'b0;
        // Data means nothing without the strobe, so stale bytes are not left up
        cfg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        cfg_addr_o = a;
        @(posedge clk_sys_i);
        #1;
        d = cfg_rdata_i;
    endtask
endmodule // hpd_cfg_host
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk_sys_i, rst_i, ce_i, use_def, self_pw, renum, wr;
    logic [7:0]  addr, wdata, rdata, draw, ctrl, rd;
    logic [7:1]  s_pos, s_neg, off;
    logic [3:0]  cnt;
    logic [20:0] phys;
    int          bad_count = 0, num_checks = 0;
    hpd_cfg_host u_host (.clk_sys_i(clk_sys_i), .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_wdata_o(wdata), .cfg_rdata_i(rdata));
    hpd_port_cfg #(.NPORT(7)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_wr_i(wr), .cfg_addr_i(addr),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .use_defaults_i(use_def), .self_powered_i(self_pw),
        .port_renumber_enable_i(renum), .port_off_strap_positive_i(s_pos), .port_off_strap_negative_i(s_neg),
        .port_off_o(off), .enabled_count_o(cnt), .phys_of_logical_o(phys), .supply_draw_o(draw), .controller_draw_o(ctrl));
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task chk(input logic [20:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Synchronisers need about five edges; eight leaves margin
    task wt;
        repeat (8) @(posedge clk_sys_i);
        #1;
    endtask
    task t_reset;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk(ctrl, 8'h32);
        rst_i = 1'b0;
        for (int i = 0; i < 6; i++) begin
            u_host.rd((i == 5) ? 8'h20 : 8'h0A + 8'(i), rd);
            chk(rd, (i == 4) ? 8'h32 : 8'h00);
        end
    endtask
    task t_self;
        self_pw = 1'b1;
        wt;
        u_host.wr(8'h0A, 8'hFF);
        u_host.rd(8'h0A, rd);
        chk(rd, 8'hFE);
        chk(off, 7'h7F);
        chk(cnt, 4'h0);
        u_host.wr(8'h0A, 8'h55);
        u_host.wr(8'h0C, 8'h2A);
        u_host.wr(8'h0E, 8'h19);
        wt;
        chk(off, 7'h2A);
        chk(cnt, 4'h4);
        chk(phys, 21'h000F59);
        chk(draw, 8'h2A);
        chk(ctrl, 8'h19);
    endtask
    task t_bus;
        self_pw = 1'b0;
        wt;
        u_host.wr(8'h0B, 8'hA3);
        u_host.wr(8'h0D, 8'h7B);
        wt;
        chk(off, 7'h51);
        chk(cnt, 4'h4);
        chk(draw, 8'h7B);
        self_pw = 1'b1;
        wt;
        chk(off, 7'h2A);
        chk(draw, 8'h2A);
    endtask
    task t_strap_remap;
        {use_def, s_pos, s_neg} = {1'b1, 7'h05, 7'h40};
        wt;
        wt;
        chk(off, 7'h45);
        {use_def, renum} = 2'b01;
        wt;
        wt;
        chk(off, 7'h00);
        renum = 1'b0;
        wt;
        chk(off, 7'h2A);
    endtask
    task t_freeze;
        ce_i = 1'b0;
        u_host.wr(8'h0C, 8'h10);
        self_pw = 1'b0;
        wt;
        chk(draw, 8'h2A);
        ce_i = 1'b1;
        wt;
        chk(draw, 8'h7B);
        u_host.rd(8'h0C, rd);
        chk(rd, 8'h2A);
        self_pw = 1'b1;
        wt;
        chk(draw, 8'h2A);
    endtask
    task summarize;
        $display("Checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #100000;
        bad_count++;
        summarize;
    end
    initial begin
        {rst_i, ce_i, use_def, self_pw, renum, s_pos, s_neg} = {2'b11, 17'h0};
        t_reset;
        t_self;
        t_bus;
        t_freeze;
        t_strap_remap;
        summarize;
    end
endmodule // testbench
`default_nettype wire
